// ==== core/dst_pkg.sv ====
/*
 Package for the dual-stage timer unit: timer indices, layouts, carriers
 and timing counts. Assumes a single 50 MHz core clock.
*/
package dst_pkg;
	localparam int unsigned CLK_PERIOD_NS    = 20;
	localparam int unsigned RESTART_CYCLES   = 2;
	localparam logic [1:0]  TMR_GEN_ONE      = 2'h0;
	localparam logic [1:0]  TMR_GEN_TWO      = 2'h1;
	localparam logic [1:0]  TMR_BAUD         = 2'h2;
	localparam logic [1:0]  TMR_WATCHDOG     = 2'h3;
	localparam int unsigned TMR_COUNT        = 4;
	localparam logic [7:0]  LATCH_RESET      = 8'hFF;
	localparam logic [7:0]  COUNT_RESET      = 8'hFF;
	localparam logic [1:0]  SEL_LOW          = 2'h0;
	localparam logic [1:0]  SEL_HIGH         = 2'h1;
	localparam logic [1:0]  SEL_FLAG         = 2'h2;

	// one processor access: timer index, which byte, data, strobes
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [1:0] timer;
		logic [1:0] sel;
		logic [7:0] data;
	} dst_access_s;

	typedef enum logic [1:0] {
		DST_RST_IDLE  = 2'b00,
		DST_RST_PULL  = 2'b01,
		DST_RST_DONE  = 2'b10
	} dst_restart_e;
endpackage : dst_pkg

// ==== core/dst_stage.sv ====
/*
 One 16-bit down-counter: low and high byte counters with reload latches.
 Assumes edge strobes come one cycle each from the parent.
*/
`timescale 1ns/1ps
module dst_stage
	import dst_pkg::*;
#(
	parameter bit HAS_PRESCALE    = 1'b1,
	// watchdog: high latch loads quietly and only arming or a timeout restarts the count
	parameter bit RESTART_ON_HIGH = 1'b1
) (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// timer clock edges, enable and prescale select
	input  wire logic       fallEdge,
	input  wire logic       riseEdge,
	input  wire logic       enable,
	input  wire logic       prescale,
	// latch writes and reload
	input  wire logic       wrLow,
	input  wire logic       wrHigh,
	input  wire logic       reload,
	input  wire logic [7:0] wrData,
	// state
	output logic      [7:0] lowCount,
	output logic      [7:0] highCount,
	output logic            timeout
);
	logic [7:0] lowLatch;
	logic [7:0] highLatch;
	logic       lowZero;
	logic       highZero;
	logic       doReload;

	assign lowZero  = (lowCount == 8'h00);
	assign highZero = (highCount == 8'h00);
	assign timeout  = enable && riseEdge && highZero;
	assign doReload = timeout || (RESTART_ON_HIGH && wrHigh) || reload;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			lowLatch  <= LATCH_RESET;
			highLatch <= LATCH_RESET;
		end else begin
			if (wrLow)
				lowLatch <= wrData;
			if (wrHigh)
				highLatch <= wrData;
		end
	end

	// latch write and reload in one cycle: take the new byte at once
	always_ff @(posedge core_clk) begin
		if (rst) begin
			lowCount  <= COUNT_RESET;
			highCount <= COUNT_RESET;
		end else if (doReload) begin
			lowCount  <= wrLow ? wrData : lowLatch;
			highCount <= wrHigh ? wrData : highLatch;
		end else if (enable && fallEdge) begin
			if (lowZero && HAS_PRESCALE && prescale)
				lowCount <= lowLatch;
			else
				lowCount <= lowCount - 8'h01;
			if (lowZero)
				highCount <= highCount - 8'h01;
		end
	end

	lowdec_a: assert property (@(posedge core_clk) disable iff (rst)
		(enable && fallEdge && !doReload && lowCount != 8'h00)
		|=> lowCount == $past(lowCount) - 8'h01)
		else $error("low counter did not step down");
	highdec_a: assert property (@(posedge core_clk) disable iff (rst)
		(enable && fallEdge && !doReload && lowZero)
		|=> highCount == $past(highCount) - 8'h01)
		else $error("high counter did not step on low zero");
	prescale_a: assert property (@(posedge core_clk) disable iff (rst)
		(HAS_PRESCALE && prescale && enable && fallEdge && lowZero && !doReload)
		|=> lowCount == $past(lowLatch))
		else $error("prescaler did not reload");
	reload_a: assert property (@(posedge core_clk) disable iff (rst)
		(RESTART_ON_HIGH && wrHigh && !wrLow)
		|=> (lowCount == lowLatch && highCount == highLatch))
		else $error("high latch write did not restart count");
endmodule : dst_stage

// ==== core/dst_timers.sv ====
/*
 Timer unit: two general timers, a baud timer and a watchdog restart timer.
 Assumes the processor access strobes last one cycle and all inputs are
 synchronous to core_clk.
*/
// Notes on behaviour
// - timer clock fall decrements low counter
// - prescale mode reloads low counter on expiry
// - watchdog has no prescale mode
// - low counter write goes to low latch
// - reads return live counter values
// - low zero at fall decrements high
// - high zero at rise sets flag on the two general timers
// - watchdog timeout pulls reset low two cycles
// - timeout reloads both counters from latches
// - high counter write stores high latch
// - high latch write restarts the count, except on the watchdog
// - watchdog idle until first arming rise
// - each arming rise reloads watchdog
// - arming fall leaves watchdog alone
// - writing one clears a flag, zero ignored
// - serial enable forces baud interval mode
`timescale 1ns/1ps
module dst_timers
	import dst_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// timer clock input
	input  wire logic        timerClk,
	// processor access
	input  dst_access_s      access,
	output logic       [7:0] readData,
	// configuration
	input  wire logic  [1:0] prescaleEn,
	input  wire logic        baudIntervalCfg,
	input  wire logic        serialEn,
	input  wire logic        watchdog_arm_bit,
	input  wire logic  [1:0] irqEnable,
	// status
	output logic       [1:0] interrupt_flag_reg,
	output logic       [1:0] timerIrq,
	output logic             baudTick,
	output logic             baudIntervalMode,
	output logic             watchdogActive,
	output logic             chip_reset_pin_n_out,
	output logic             chip_reset_pin_n_oe
);
	logic        tclkPrev;
	logic        fallEdge;
	logic        riseEdge;
	logic        armPrev;
	logic        armRise;
	logic [7:0]  lowCount  [TMR_COUNT];
	logic [7:0]  highCount [TMR_COUNT];
	logic [TMR_COUNT-1:0] timeout;
	logic [TMR_COUNT-1:0] wrLow;
	logic [TMR_COUNT-1:0] wrHigh;
	logic        flagClearWr;
	dst_restart_e rstState;
	dst_restart_e next_rstState;
	logic [1:0]  pullCount;

	function automatic logic hits(input dst_access_s a, input logic [1:0] t,
		input logic [1:0] s);
		hits = a.wr && a.timer == t && a.sel == s;
	endfunction : hits

	assign fallEdge    = tclkPrev && !timerClk;
	assign riseEdge    = !tclkPrev && timerClk;
	assign armRise     = watchdog_arm_bit && !armPrev;
	assign flagClearWr = access.wr && access.sel == SEL_FLAG;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tclkPrev <= 1'b1;
			// start high so an arming bit held through reset is no rise
			armPrev  <= 1'b1;
		end else begin
			tclkPrev <= timerClk;
			armPrev  <= watchdog_arm_bit;
		end
	end

	for (genvar i = 0; i < TMR_COUNT; i++) begin : g_tmr
		assign wrLow[i]  = hits(access, 2'(i), SEL_LOW);
		// the watchdog high latch loads without restarting; arming does that
		assign wrHigh[i] = hits(access, 2'(i), SEL_HIGH);
		dst_stage #(
			.HAS_PRESCALE    (i < 2),
			.RESTART_ON_HIGH (i != TMR_WATCHDOG)
		) u_stage (
			.core_clk  (core_clk),
			.rst       (rst),
			.fallEdge  (fallEdge),
			.riseEdge  (riseEdge),
			.enable    ((i == TMR_WATCHDOG) ? watchdogActive : 1'b1),
			.prescale  ((i < 2) ? prescaleEn[i % 2] : 1'b0),
			.wrLow     (wrLow[i]),
			.wrHigh    (wrHigh[i]),
			.reload    ((i == TMR_WATCHDOG) && armRise),
			.wrData    (access.data),
			.lowCount  (lowCount[i]),
			.highCount (highCount[i]),
			.timeout   (timeout[i])
		);
	end

	// the reset pin is only ever driven low, never high
	pin_drive_a: assert property (@(posedge core_clk) disable iff (rst)
		chip_reset_pin_n_oe == !chip_reset_pin_n_out)
		else $error("reset pin driven while released");
	irq_gate_a: assert property (@(posedge core_clk) disable iff (rst)
		!(|irqEnable) |=> timerIrq == 2'h0)
		else $error("interrupt raised while disabled");

	always_ff @(posedge core_clk) begin
		if (rst)
			watchdogActive <= 1'b0;
		else if (armRise)
			watchdogActive <= 1'b1;
	end

	// set wins over a clear landing in the same cycle
	always_ff @(posedge core_clk) begin
		if (rst)
			interrupt_flag_reg <= 2'h0;
		else begin
			for (int k = 0; k < 2; k++) begin
				if (timeout[k])
					interrupt_flag_reg[k] <= 1'b1;
				else if (flagClearWr && access.data[k])
					interrupt_flag_reg[k] <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			timerIrq <= 2'h0;
		else
			timerIrq <= interrupt_flag_reg & irqEnable;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			baudTick         <= 1'b0;
			baudIntervalMode <= 1'b0;
		end else begin
			baudTick         <= timeout[TMR_BAUD];
			baudIntervalMode <= serialEn || baudIntervalCfg;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			readData <= 8'h00;
		else if (access.rd) begin
			case (access.sel)
				SEL_LOW:  readData <= lowCount[access.timer];
				SEL_HIGH: readData <= highCount[access.timer];
				SEL_FLAG: readData <= {6'h00, interrupt_flag_reg};
				default:  readData <= 8'h00;
			endcase
		end
	end

	always_comb begin
		next_rstState = rstState;
		case (rstState)
			DST_RST_IDLE: if (timeout[TMR_WATCHDOG]) next_rstState = DST_RST_PULL;
			DST_RST_PULL: if (pullCount == 2'(RESTART_CYCLES - 1))
				next_rstState = DST_RST_DONE;
			DST_RST_DONE: next_rstState = DST_RST_DONE;
			default:      next_rstState = DST_RST_IDLE;
		endcase
	end

	// after the pulse the chip reset arrives on rst and returns us to idle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rstState             <= DST_RST_IDLE;
			pullCount            <= 2'h0;
			chip_reset_pin_n_out <= 1'b1;
			chip_reset_pin_n_oe  <= 1'b0;
		end else begin
			rstState             <= next_rstState;
			pullCount            <= (next_rstState == DST_RST_PULL && rstState == DST_RST_PULL)
				? pullCount + 2'h1 : 2'h0;
			chip_reset_pin_n_out <= (next_rstState != DST_RST_PULL);
			chip_reset_pin_n_oe  <= (next_rstState == DST_RST_PULL);
		end
	end

	sequence wdExpire_s;
		timeout[TMR_WATCHDOG] && rstState == DST_RST_IDLE;
	endsequence
	sequence pullTwo_s;
		chip_reset_pin_n_oe [*2] ##1 !chip_reset_pin_n_oe;
	endsequence
	restart_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
		wdExpire_s |=> pullTwo_s)
		else $error("restart pulse not two cycles");
	flag_set_a: assert property (@(posedge core_clk) disable iff (rst)
		timeout[0] |=> interrupt_flag_reg[0])
		else $error("timer one flag not set");
	flag_clear_a: assert property (@(posedge core_clk) disable iff (rst)
		(flagClearWr && access.data[1] && !timeout[1]) |=> !interrupt_flag_reg[1])
		else $error("flag not cleared by one");
	flag_keep_a: assert property (@(posedge core_clk) disable iff (rst)
		(flagClearWr && !access.data[0] && interrupt_flag_reg[0]) |=> interrupt_flag_reg[0])
		else $error("flag lost on zero write");
	wd_idle_a: assert property (@(posedge core_clk) disable iff (rst)
		!watchdogActive |-> !timeout[TMR_WATCHDOG])
		else $error("watchdog ran before arming");
	arm_fall_a: assert property (@(posedge core_clk) disable iff (rst)
		$fell(watchdog_arm_bit) && watchdogActive |=> watchdogActive)
		else $error("arming fall stopped watchdog");
	baud_force_a: assert property (@(posedge core_clk) disable iff (rst)
		serialEn |=> baudIntervalMode)
		else $error("baud not forced to interval mode");
	read_live_a: assert property (@(posedge core_clk) disable iff (rst)
		(access.rd && access.sel == SEL_LOW) |=> readData == $past(lowCount[access.timer]))
		else $error("read did not return counter");
endmodule : dst_timers

// ==== testbench/dst_cpu_model.sv ====
/*
 Processor-side model of the timer unit: one-cycle write and read strobes.
 Assumes the bench calls its tasks from one process at a time.
*/
`timescale 1ns/1ps
module dst_cpu_model
	import dst_pkg::*;
(
	// clock
	input  wire logic        core_clk,
	// processor access
	output dst_access_s      access,
	input  wire logic  [7:0] readData
);
	initial access = '0;

	// strobe for one cycle, then idle one cycle so strobes never merge
	task automatic wr(input logic [1:0] t, input logic [1:0] s, input logic [7:0] d);
		@(negedge core_clk);
		access <= '{wr: 1'b1, rd: 1'b0, timer: t, sel: s, data: d};
		@(negedge core_clk);
		access <= '0;
	endtask : wr

	// read result is registered at the edge that takes the strobe
	task automatic rd(input logic [1:0] t, input logic [1:0] s, output logic [7:0] d);
		@(negedge core_clk);
		access <= '{wr: 1'b0, rd: 1'b1, timer: t, sel: s, data: 8'h00};
		@(negedge core_clk);
		access <= '0;
		d = readData;
	endtask : rd
endmodule : dst_cpu_model

// ==== testbench/dual_stage_timers_with_restart_tb.sv ====
/*
 Self-checking bench for the timer unit, with a processor model on the access port.
 Assumes a 50 MHz core clock and a slow timer clock driven by the bench.
*/
`timescale 1ns/1ps
module dual_stage_timers_with_restart_tb;
	import dst_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        timerClk = 1'b1;
	logic [1:0]  prescaleEn = 2'h0;
	logic        baudIntervalCfg = 1'b0;
	logic        serialEn = 1'b0;
	logic        armBit = 1'b0;
	logic [1:0]  irqEnable = 2'h0;
	dst_access_s access;
	logic [7:0]  readData;
	logic [1:0]  flags;
	logic [1:0]  timerIrq;
	logic        baudIntervalMode;
	logic        watchdogActive;
	logic        baudTick;
	int          nBaud = 0;
	logic        pinOut;
	logic        pinOe;
	logic [7:0]  v;
	logic [7:0]  lowVal;
	int          nErrors = 0;
	int          totalChecks = 0;
	int          nLow = 0;
	int          k;

	always #10 core_clk = ~core_clk;

	dst_cpu_model u_cpu (.core_clk(core_clk), .access(access), .readData(readData));

	dst_timers u_dut (
		.core_clk(core_clk), .rst(rst), .timerClk(timerClk), .access(access),
		.readData(readData), .prescaleEn(prescaleEn), .baudIntervalCfg(baudIntervalCfg),
		.serialEn(serialEn), .watchdog_arm_bit(armBit), .irqEnable(irqEnable),
		.interrupt_flag_reg(flags), .timerIrq(timerIrq), .baudTick(baudTick),
		.baudIntervalMode(baudIntervalMode), .watchdogActive(watchdogActive),
		.chip_reset_pin_n_out(pinOut), .chip_reset_pin_n_oe(pinOe)
	);

	// width of the restart pulse in core cycles, and number of baud ticks
	always @(negedge core_clk) begin
		if (pinOe === 1'b1 && pinOut === 1'b0) nLow++;
		if (baudTick === 1'b1) nBaud++;
	end

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			nErrors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// each timer clock level is held long enough for edge detection to settle
	task automatic edgeT(input logic lvl);
		@(negedge core_clk);
		timerClk = lvl;
		repeat (3) @(negedge core_clk);
	endtask : edgeT

	task automatic tick(input int n);
		repeat (n) begin
			edgeT(1'b0);
			edgeT(1'b1);
		end
	endtask : tick

	task automatic settle();
		repeat (3) @(negedge core_clk);
	endtask : settle

	task automatic wrapUp();
		$display("checks %0d errors %0d", totalChecks, nErrors);
		if (nErrors == 0 && totalChecks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrapUp

	initial begin
		#500us;
		nErrors++;
		wrapUp();
	end

	initial begin
		void'($urandom(32'hCFCF));
		repeat (4) @(negedge core_clk);
		rst = 1'b0;
		chk("pin idle", pinOut, 8'h01);
		u_cpu.rd(TMR_GEN_ONE, SEL_LOW, v);
		chk("low reset", v, COUNT_RESET);
		u_cpu.wr(TMR_GEN_ONE, SEL_LOW, 8'h5A);
		u_cpu.rd(TMR_GEN_ONE, SEL_LOW, v);
		chk("low write to latch", v, COUNT_RESET);
		u_cpu.wr(TMR_GEN_ONE, SEL_HIGH, 8'h03);
		u_cpu.rd(TMR_GEN_ONE, SEL_LOW, v);
		chk("restart low", v, 8'h5A);
		u_cpu.rd(TMR_GEN_ONE, SEL_HIGH, v);
		chk("restart high", v, 8'h03);
		// random start values and edge counts; high stays nonzero throughout
		repeat (3) begin
			lowVal = 8'($urandom_range(8'hFF, 8'h10));
			k = $urandom_range(8, 1);
			u_cpu.wr(TMR_GEN_ONE, SEL_LOW, lowVal);
			u_cpu.wr(TMR_GEN_ONE, SEL_HIGH, 8'h01);
			tick(k);
			u_cpu.rd(TMR_GEN_ONE, SEL_LOW, v);
			chk("low count", v, 8'(lowVal - k));
			u_cpu.rd(TMR_GEN_ONE, SEL_HIGH, v);
			chk("high held", v, 8'h01);
		end
		u_cpu.wr(TMR_GEN_ONE, SEL_LOW, 8'h00);
		u_cpu.wr(TMR_GEN_ONE, SEL_HIGH, 8'h02);
		tick(1);
		u_cpu.rd(TMR_GEN_ONE, SEL_HIGH, v);
		chk("high borrow", v, 8'h01);
		irqEnable = 2'b01;
		u_cpu.wr(TMR_GEN_ONE, SEL_LOW, 8'h03);
		u_cpu.wr(TMR_GEN_ONE, SEL_HIGH, 8'h00);
		tick(1);
		u_cpu.rd(TMR_GEN_ONE, SEL_LOW, v);
		chk("timeout reload", v, 8'h03);
		chk("flag set", {6'h00, flags}, 8'h01);
		chk("irq out", {6'h00, timerIrq}, 8'h01);
		u_cpu.wr(TMR_GEN_ONE, SEL_FLAG, 8'h00);
		settle();
		chk("flag kept", {6'h00, flags}, 8'h01);
		u_cpu.wr(TMR_GEN_ONE, SEL_FLAG, 8'h01);
		settle();
		chk("flag cleared", {6'h00, flags}, 8'h00);
		// prescale: low runs 2,1,0 then reloads instead of wrapping
		prescaleEn = 2'b10;
		u_cpu.wr(TMR_GEN_TWO, SEL_LOW, 8'h02);
		u_cpu.wr(TMR_GEN_TWO, SEL_HIGH, 8'h03);
		tick(3);
		u_cpu.rd(TMR_GEN_TWO, SEL_LOW, v);
		chk("prescale reload", v, 8'h02);
		u_cpu.rd(TMR_GEN_TWO, SEL_HIGH, v);
		chk("prescale high", v, 8'h02);
		for (int i = 0; i < 4; i++) begin
			{serialEn, baudIntervalCfg} = 2'(i);
			settle();
			chk("baud mode", baudIntervalMode, 8'(i != 0));
		end
		u_cpu.wr(TMR_BAUD, SEL_LOW, 8'h01);
		u_cpu.wr(TMR_BAUD, SEL_HIGH, 8'h00);
		u_cpu.rd(TMR_BAUD, SEL_LOW, v);
		chk("baud restart", v, 8'h01);
		chk("baud quiet", 8'(nBaud), 8'h00);
		tick(1);
		chk("baud tick", 8'(nBaud), 8'h01);
		u_cpu.wr(TMR_WATCHDOG, SEL_LOW, 8'h05);
		u_cpu.wr(TMR_WATCHDOG, SEL_HIGH, 8'h01);
		tick(1);
		chk("wd idle", watchdogActive, 8'h00);
		armBit = 1'b1;
		settle();
		chk("wd armed", watchdogActive, 8'h01);
		u_cpu.rd(TMR_WATCHDOG, SEL_LOW, v);
		chk("wd reload", v, 8'h05);
		tick(2);
		armBit = 1'b0;
		settle();
		u_cpu.rd(TMR_WATCHDOG, SEL_LOW, v);
		chk("wd disarm ignored", v, 8'h03);
		u_cpu.wr(TMR_WATCHDOG, SEL_LOW, 8'h01);
		u_cpu.wr(TMR_WATCHDOG, SEL_HIGH, 8'h00);
		armBit = 1'b1;
		settle();
		chk("no early pulse", 8'(nLow), 8'h00);
		tick(1);
		repeat (6) @(negedge core_clk);
		chk("restart pulse", 8'(nLow), 8'(RESTART_CYCLES));
		// the pulse restarts the chip; arming stays high through that reset
		rst = 1'b1;
		repeat (4) @(negedge core_clk);
		rst = 1'b0;
		chk("pin released", {6'h00, pinOe, pinOut}, 8'h01);
		settle();
		chk("wd idle after reset", watchdogActive, 8'h00);
		u_cpu.rd(TMR_GEN_ONE, SEL_LOW, v);
		chk("low after reset", v, COUNT_RESET);
		armBit = 1'b0;
		settle();
		armBit = 1'b1;
		settle();
		chk("wd rearmed", watchdogActive, 8'h01);
		wrapUp();
	end
endmodule : dual_stage_timers_with_restart_tb
